// ===== shared/cdc_pkg.sv
// constants, states and types of the core debug command port
package cdc_pkg;
  typedef enum logic [3:0] {
    st_tlr, st_rti, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pau_dr, st_ex2_dr,
    st_upd_dr, st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pau_ir, st_ex2_ir, st_upd_ir
  } cdc_tap_e;
  typedef enum logic [1:0] {own_none, own_core0, own_core1, own_chain} cdc_owner_e;
  typedef enum logic [1:0] {res_bypass, res_id, res_shared, res_ext} cdc_res_e;

  localparam int IR_W = 5;
  localparam logic [4:0] IR_IDCODE = 5'h01;
  localparam logic [4:0] IR_SAMPLE_PRE = 5'h02;
  localparam logic [4:0] IR_SAMPLE = 5'h03;
  localparam logic [4:0] IR_EXTEST = 5'h04;
  localparam logic [4:0] IR_AUX_CORE1 = 5'h11;
  localparam logic [4:0] IR_AUX_CORE0 = 5'h19;
  localparam logic [4:0] IR_AUX_CHAIN = 5'h1c;
  localparam logic [4:0] IR_BYPASS = 5'h1f;
  localparam logic [4:0] IR_CAPTURE = 5'h01;

  localparam int CMD_W = 10;
  localparam int RS_W = 7;
  localparam int CMD_RW_BIT = 9;
  localparam int CMD_GO_BIT = 8;
  localparam int CMD_EXIT_BIT = 7;
  localparam logic [9:0] CMD_CAPTURE = 10'h001;
  localparam logic [9:0] CMD_RESET = 10'h07f;

  localparam logic [6:0] RS_JTAG_ID = 7'h02;
  localparam logic [6:0] RS_CPU_SCAN = 7'h10;
  localparam logic [6:0] RS_BYPASS_A = 7'h11;
  localparam logic [6:0] RS_DBG_CTRL = 7'h12;
  localparam logic [6:0] RS_IAC_FIRST = 7'h20;
  localparam logic [6:0] RS_IAC_LAST = 7'h23;
  localparam logic [6:0] RS_DAC_FIRST = 7'h24;
  localparam logic [6:0] RS_DAC_LAST = 7'h25;
  localparam logic [6:0] RS_STATUS = 7'h30;
  localparam logic [6:0] RS_DBCR_FIRST = 7'h31;
  localparam logic [6:0] RS_DBCR_LAST = 7'h33;
  localparam logic [6:0] RS_SHARED = 7'h6f;
  localparam logic [6:0] RS_GPR_FIRST = 7'h70;
  localparam logic [6:0] RS_GPR_LAST = 7'h79;
  localparam logic [6:0] RS_TRACE_UNIT = 7'h7c;
  localparam logic [6:0] RS_FACTORY = 7'h7d;
  localparam logic [6:0] RS_DBG_ENABLE = 7'h7e;
  localparam logic [6:0] RS_BYPASS_B = 7'h7f;

  localparam int DR_W = 32;
  localparam int BSR_LEN = 8;
  localparam int HALT_EN_LSB = 22;
  localparam int MASTER_ID_LSB = 26;
  localparam int TRACE_OWNER_LSB = 30;
  localparam logic [31:0] SHARED_RESET = 32'h0000_0000;
  localparam logic [31:0] SHARED_MASK = 32'hccc0_0000;

  function automatic cdc_tap_e cdc_next(cdc_tap_e s, logic tms);
    case (s)
      st_tlr: cdc_next = tms ? st_tlr : st_rti;
      st_rti: cdc_next = tms ? st_sel_dr : st_rti;
      st_sel_dr: cdc_next = tms ? st_sel_ir : st_cap_dr;
      st_cap_dr: cdc_next = tms ? st_ex1_dr : st_sh_dr;
      st_sh_dr: cdc_next = tms ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: cdc_next = tms ? st_upd_dr : st_pau_dr;
      st_pau_dr: cdc_next = tms ? st_ex2_dr : st_pau_dr;
      st_ex2_dr: cdc_next = tms ? st_upd_dr : st_sh_dr;
      st_upd_dr: cdc_next = tms ? st_sel_dr : st_rti;
      st_sel_ir: cdc_next = tms ? st_tlr : st_cap_ir;
      st_cap_ir: cdc_next = tms ? st_ex1_ir : st_sh_ir;
      st_sh_ir: cdc_next = tms ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: cdc_next = tms ? st_upd_ir : st_pau_ir;
      st_pau_ir: cdc_next = tms ? st_ex2_ir : st_pau_ir;
      st_ex2_ir: cdc_next = tms ? st_upd_ir : st_sh_ir;
      st_upd_ir: cdc_next = tms ? st_sel_dr : st_rti;
      default: cdc_next = st_tlr;
    endcase
  endfunction
endpackage

// ===== shared/cdc_pin_if.sv
// synchronised probe pins and tck edges
`timescale 1ns/100ps
interface cdc_pin_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic enable;
  logic event_n;
  logic [7:0] pad;
  modport src(output tck_rise, output tck_fall, output tms, output tdi, output enable, output event_n, output pad);
  modport dst(input tck_rise, input tck_fall, input tms, input tdi, input enable, input event_n, input pad);
endinterface

// ===== logic/cdc_pin_sync.sv
// two-flop synchronisers for probe pins and tck edge finder
`timescale 1ns/100ps
module cdc_pin_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tap_enable_pin,
  input wire logic probe_event_input_n,
  input wire logic [7:0] pad_in,
  cdc_pin_if.src pins
);
  logic [12:0] s1;
  logic [12:0] s2;
  logic tck_d;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1 <= 13'h0010;
      s2 <= 13'h0010;
    end else begin
      s1 <= {pad_in, probe_event_input_n, tap_enable_pin, tdi, tms, tck};
      s2 <= s1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= s2[0];
    end
  end

  assign pins.tck_rise = s2[0] & ~tck_d;
  assign pins.tck_fall = ~s2[0] & tck_d;
  assign pins.tms = s2[1];
  assign pins.tdi = s2[2];
  assign pins.enable = s2[3];
  assign pins.event_n = s2[4];
  assign pins.pad = s2[12:5];
endmodule

// ===== logic/cdc_debug_port.sv
// shared test port, boundary chain and two core debug command tap controllers
`timescale 1ns/100ps
module cdc_debug_port #(
  parameter logic [31:0] DEVICE_ID = 32'h1000_0001,
  parameter logic [31:0] CORE0_ID = 32'h1000_1001,
  parameter logic [31:0] CORE1_ID = 32'h1000_2001
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic tap_enable_pin,
  input wire logic probe_event_input_n,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic boundary_drive,
  output logic [1:0] core_halt_request,
  output logic trace_owner_select,
  output logic master_id_select,
  output logic [1:0] core_access_strobe,
  output logic [1:0][6:0] core_access_rs,
  output logic [1:0] core_access_write,
  output logic [1:0][31:0] core_access_wdata,
  input wire logic [1:0][31:0] core_access_rdata,
  output logic [1:0] core_go_strobe,
  output logic [1:0] core_exit_strobe
);
  cdc_pin_if pins ();

  // pins synchronised, tck found by sampling
  cdc_pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tap_enable_pin(tap_enable_pin),
    .probe_event_input_n(probe_event_input_n),
    .pad_in(pad_in),
    .pins(pins)
  );

  function automatic cdc_pkg::cdc_res_e decode_rs(logic [6:0] rs, logic has_shared);
    decode_rs = cdc_pkg::res_bypass;
    if (rs == cdc_pkg::RS_JTAG_ID) begin
      decode_rs = cdc_pkg::res_id;
    end
    if (rs == cdc_pkg::RS_CPU_SCAN || rs == cdc_pkg::RS_DBG_CTRL) begin
      decode_rs = cdc_pkg::res_ext;
    end
    if (rs >= cdc_pkg::RS_IAC_FIRST && rs <= cdc_pkg::RS_DAC_LAST) begin
      decode_rs = cdc_pkg::res_ext;
    end
    if (rs == cdc_pkg::RS_STATUS || (rs >= cdc_pkg::RS_DBCR_FIRST && rs <= cdc_pkg::RS_DBCR_LAST)) begin
      decode_rs = cdc_pkg::res_ext;
    end
    // shared register on first core only
    if (rs == cdc_pkg::RS_SHARED && has_shared) begin
      decode_rs = cdc_pkg::res_shared;
    end
    if (rs >= cdc_pkg::RS_GPR_FIRST && rs <= cdc_pkg::RS_GPR_LAST) begin
      decode_rs = cdc_pkg::res_ext;
    end
    // trace unit, factory scan, debug enable
    if (rs == cdc_pkg::RS_TRACE_UNIT || rs == cdc_pkg::RS_FACTORY || rs == cdc_pkg::RS_DBG_ENABLE) begin
      decode_rs = cdc_pkg::res_ext;
    end
    // explicit bypass codes; reserved codes also fall to bypass
    if (rs == cdc_pkg::RS_BYPASS_A || rs == cdc_pkg::RS_BYPASS_B) begin
      decode_rs = cdc_pkg::res_bypass;
    end
  endfunction

  function automatic logic is_bsr(logic [4:0] code);
    is_bsr = code == cdc_pkg::IR_SAMPLE_PRE || code == cdc_pkg::IR_SAMPLE || code == cdc_pkg::IR_EXTEST;
  endfunction

  cdc_pkg::cdc_tap_e st;
  cdc_pkg::cdc_owner_e owner;
  logic [4:0] ir_sh;
  logic [4:0] ir;
  logic pause_seen;
  logic [31:0] dr;
  logic [31:0] shared_ctrl;
  logic main_so;
  logic next_tdo;

  cdc_pkg::cdc_tap_e cst [2];
  logic [9:0] csh [2];
  logic [9:0] cmd [2];
  logic [31:0] cdr [2];
  logic cso [2];
  logic ctdi [2];
  logic owned [2];
  cdc_pkg::cdc_res_e kind [2];

  // main tap state machine
  // enable pin low holds test logic reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= cdc_pkg::st_tlr;
    end else if (!pins.enable) begin
      st <= cdc_pkg::st_tlr;
    end else if (pins.tck_rise) begin
      st <= cdc_pkg::cdc_next(st, pins.tms);
    end
  end

  // instruction register and port ownership
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ir_sh <= cdc_pkg::IR_CAPTURE;
      ir <= cdc_pkg::IR_IDCODE;
      owner <= cdc_pkg::own_none;
      pause_seen <= 1'b0;
    end else if (!pins.enable) begin
      ir <= cdc_pkg::IR_IDCODE;
      owner <= cdc_pkg::own_none;
      pause_seen <= 1'b0;
    end else if (pins.tck_rise) begin
      case (st)
        cdc_pkg::st_tlr: begin
          ir <= cdc_pkg::IR_IDCODE;
          owner <= cdc_pkg::own_none;
          pause_seen <= 1'b0;
        end
        cdc_pkg::st_cap_ir: begin
          if (owner == cdc_pkg::own_none) begin
            ir_sh <= cdc_pkg::IR_CAPTURE;
          end
        end
        cdc_pkg::st_sh_ir: begin
          if (owner == cdc_pkg::own_none) begin
            ir_sh <= {pins.tdi, ir_sh[4:1]};
          end
        end
        cdc_pkg::st_upd_ir: begin
          if (owner == cdc_pkg::own_none) begin
            ir <= ir_sh;
            case (ir_sh)
              cdc_pkg::IR_AUX_CORE1: owner <= cdc_pkg::own_core1;
              cdc_pkg::IR_AUX_CORE0: owner <= cdc_pkg::own_core0;
              cdc_pkg::IR_AUX_CHAIN: owner <= cdc_pkg::own_chain;
              default: owner <= cdc_pkg::own_none;
            endcase
          end
        end
        cdc_pkg::st_pau_dr: begin
          if (owner != cdc_pkg::own_none) begin
            pause_seen <= 1'b1;
          end
        end
        cdc_pkg::st_upd_dr: begin
          if (owner != cdc_pkg::own_none && pause_seen) begin
            owner <= cdc_pkg::own_none;
            ir <= cdc_pkg::IR_BYPASS;
            pause_seen <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // main data path: id, boundary chain or bypass
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dr <= 32'h0000_0000;
    end else if (pins.enable && pins.tck_rise && owner == cdc_pkg::own_none) begin
      case (st)
        cdc_pkg::st_cap_dr: begin
          if (ir == cdc_pkg::IR_IDCODE) begin
            dr <= DEVICE_ID;
          end else if (is_bsr(ir)) begin
            dr <= {24'h00_0000, pins.pad};
          end else begin
            dr <= 32'h0000_0000;
          end
        end
        cdc_pkg::st_sh_dr: begin
          if (ir == cdc_pkg::IR_IDCODE) begin
            dr <= {pins.tdi, dr[31:1]};
          end else if (is_bsr(ir)) begin
            // boundary cells between TDI and TDO
            dr <= {24'h00_0000, pins.tdi, dr[7:1]};
          end else begin
            dr <= {31'h0000_0000, pins.tdi};
          end
        end
        default: begin
        end
      endcase
    end
  end

  // boundary update cells; sample alone has no update action
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pad_out <= 8'h00;
      boundary_drive <= 1'b0;
    end else begin
      boundary_drive <= pins.enable && owner == cdc_pkg::own_none && ir == cdc_pkg::IR_EXTEST;
      if (pins.enable && pins.tck_rise && owner == cdc_pkg::own_none && st == cdc_pkg::st_upd_dr &&
          (ir == cdc_pkg::IR_SAMPLE_PRE || ir == cdc_pkg::IR_EXTEST)) begin
        pad_out <= dr[7:0];
      end
    end
  end

  assign main_so = (st == cdc_pkg::st_sh_ir) ? ir_sh[0] : dr[0];

  always_comb begin
    case (owner)
      cdc_pkg::own_core0: next_tdo = cso[0];
      cdc_pkg::own_core1: next_tdo = cso[1];
      cdc_pkg::own_chain: next_tdo = cso[0];
      default: next_tdo = main_so;
    endcase
  end

  // tdo changes on falling tck
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!pins.enable) begin
      tdo_oe <= 1'b0;
    end else if (pins.tck_fall) begin
      tdo <= next_tdo;
      tdo_oe <= st == cdc_pkg::st_sh_dr || st == cdc_pkg::st_sh_ir;
    end
  end

  assign owned[0] = owner == cdc_pkg::own_core0 || owner == cdc_pkg::own_chain;
  assign owned[1] = owner == cdc_pkg::own_core1 || owner == cdc_pkg::own_chain;
  // chained: second core output into first core
  assign ctdi[0] = (owner == cdc_pkg::own_chain) ? cso[1] : pins.tdi;
  assign ctdi[1] = pins.tdi;

  for (genvar g = 0; g < 2; g++) begin : g_core
    assign kind[g] = decode_rs(cmd[g][6:0], g == 0);
    assign cso[g] = (cst[g] == cdc_pkg::st_sh_ir) ? csh[g][0] : cdr[g][0];

    // core tap state and shift paths
    // nothing decays while tck stands still
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        cst[g] <= cdc_pkg::st_rti;
        csh[g] <= cdc_pkg::CMD_CAPTURE;
        cmd[g] <= cdc_pkg::CMD_RESET;
        cdr[g] <= 32'h0000_0000;
      end else if (!owned[g]) begin
        cst[g] <= cdc_pkg::st_rti;
      end else if (pins.tck_rise) begin
        cst[g] <= cdc_pkg::cdc_next(cst[g], pins.tms);
        case (cst[g])
          cdc_pkg::st_cap_ir: csh[g] <= cdc_pkg::CMD_CAPTURE;
          cdc_pkg::st_sh_ir: csh[g] <= {ctdi[g], csh[g][9:1]};
          cdc_pkg::st_upd_ir: cmd[g] <= csh[g];
          cdc_pkg::st_cap_dr: begin
            case (kind[g])
              cdc_pkg::res_id: cdr[g] <= (g == 0) ? CORE0_ID : CORE1_ID;
              cdc_pkg::res_shared: cdr[g] <= shared_ctrl;
              cdc_pkg::res_ext: cdr[g] <= core_access_rdata[g];
              default: cdr[g] <= 32'h0000_0000;
            endcase
          end
          cdc_pkg::st_sh_dr: begin
            if (kind[g] == cdc_pkg::res_bypass) begin
              cdr[g] <= {31'h0000_0000, ctdi[g]};
            end else begin
              cdr[g] <= {ctdi[g], cdr[g][31:1]};
            end
          end
          default: begin
          end
        endcase
      end
    end

    // one-cycle access pulses
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        core_access_strobe[g] <= 1'b0;
        core_access_rs[g] <= 7'h00;
        core_access_write[g] <= 1'b0;
        core_access_wdata[g] <= 32'h0000_0000;
        core_go_strobe[g] <= 1'b0;
        core_exit_strobe[g] <= 1'b0;
      end else begin
        core_access_strobe[g] <= 1'b0;
        core_go_strobe[g] <= 1'b0;
        core_exit_strobe[g] <= 1'b0;
        if (owned[g] && pins.tck_rise && cst[g] == cdc_pkg::st_upd_dr) begin
          core_access_strobe[g] <= kind[g] == cdc_pkg::res_ext;
          core_access_rs[g] <= cmd[g][6:0];
          core_access_write[g] <= ~cmd[g][cdc_pkg::CMD_RW_BIT];
          core_access_wdata[g] <= cdr[g];
          // go and exit only at update-DR
          core_go_strobe[g] <= cmd[g][cdc_pkg::CMD_GO_BIT];
          core_exit_strobe[g] <= cmd[g][cdc_pkg::CMD_EXIT_BIT];
        end
      end
    end
  end

  // shared trace control register, first core only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shared_ctrl <= cdc_pkg::SHARED_RESET;
    end else if (owned[0] && pins.tck_rise && cst[0] == cdc_pkg::st_upd_dr &&
                 kind[0] == cdc_pkg::res_shared && !cmd[0][cdc_pkg::CMD_RW_BIT]) begin
      shared_ctrl <= cdr[0] & cdc_pkg::SHARED_MASK;
    end
  end

  // decoded shared fields
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_halt_request <= 2'b00;
      trace_owner_select <= 1'b0;
      master_id_select <= 1'b0;
    end else begin
      // event-in routed per enable bits; trace unit gate lies outside
      core_halt_request[0] <= ~pins.event_n & shared_ctrl[cdc_pkg::HALT_EN_LSB];
      core_halt_request[1] <= ~pins.event_n & shared_ctrl[cdc_pkg::HALT_EN_LSB + 1];
      // owner second core only for 01
      trace_owner_select <= shared_ctrl[cdc_pkg::TRACE_OWNER_LSB +: 2] == 2'h1;
      // master id second core only for 01
      // label only; trace accesses stay with first core
      master_id_select <= shared_ctrl[cdc_pkg::MASTER_ID_LSB +: 2] == 2'h1;
    end
  end
endmodule

// ===== sim/cdc_port_properties.sv
// concurrent checks on the debug command port pins
`timescale 1ns/100ps
module cdc_port_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tap_enable_pin,
  input wire logic probe_event_input_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [7:0] pad_out,
  input wire logic boundary_drive,
  input wire logic [1:0] core_halt_request,
  input wire logic trace_owner_select,
  input wire logic master_id_select,
  input wire logic [1:0] core_access_strobe,
  input wire logic [1:0][6:0] core_access_rs,
  input wire logic [1:0] core_go_strobe,
  input wire logic [1:0] core_exit_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [5:0] strobes;
  assign strobes = {core_access_strobe, core_go_strobe, core_exit_strobe};
  // codes that name a core resource
  function automatic logic ext_code(logic [6:0] c);
    return c == 7'h10 || c == 7'h12 || (c >= 7'h20 && c <= 7'h25) || (c >= 7'h30 && c <= 7'h33)
      || (c >= 7'h70 && c <= 7'h79) || (c >= 7'h7c && c <= 7'h7e);
  endfunction
  sequence s_tck_still;
    (tap_enable_pin && tck == $past(tck))[*6];
  endsequence
  sequence s_port_off;
    !tap_enable_pin[*6];
  endsequence
  sequence s_event_idle;
    probe_event_input_n[*5];
  endsequence
  a_strobe_one_clk: assert property (strobes != 0 |=> (strobes & $past(strobes)) == 0)
    else $error("strobe longer than one clock");
  a_strobe_after_tck: assert property (strobes != 0 |-> $past(tck, 3) || $past(tck, 4) || $past(tck, 5))
    else $error("strobe without a tck rise");
  a_core0_code_map: assert property (core_access_strobe[0] |-> ext_code(core_access_rs[0]))
    else $error("first core access on unmapped code");
  a_core1_code_map: assert property (core_access_strobe[1] |-> ext_code(core_access_rs[1]))
    else $error("second core access on unmapped code");
  a_halt_needs_event: assert property (s_event_idle |-> core_halt_request == 2'b00)
    else $error("halt request with event idle");
  a_still_tck_hold: assert property (s_tck_still |=> $stable(tdo) && $stable(tdo_oe) && $stable(pad_out)
    && $stable(core_access_rs) && $stable({trace_owner_select, master_id_select}) && strobes == 0)
    else $error("state moved with tck stopped");
  a_port_off_quiet: assert property (s_port_off |-> !tdo_oe && !boundary_drive && strobes == 0)
    else $error("port active with enable low");
  a_drive_no_core: assert property (boundary_drive |-> strobes == 0)
    else $error("core access during external test");
endmodule
bind cdc_debug_port cdc_port_props u_props (.clk, .reset, .tck, .tap_enable_pin, .probe_event_input_n, .tdo,
  .tdo_oe, .pad_out, .boundary_drive, .core_halt_request, .trace_owner_select, .master_id_select,
  .core_access_strobe, .core_access_rs, .core_go_strobe, .core_exit_strobe);

// ===== sim/cdc_probe_model.sv
// probe model driving the test port pins
`timescale 1ns/100ps
module cdc_probe_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic tap_enable_pin,
  output logic probe_event_input_n,
  input wire logic tdo
);
  int stall = 0;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    tap_enable_pin = 1'b0;
    probe_event_input_n = 1'b1;
  end
  // tms, tdi and tck edges kept 1 ns off clk edges, tck may park
  task automatic step(input logic m, input logic d, output logic q);
    #1;
    tms = m;
    tdi = d;
    #(14 + stall) tck = 1'b1;
    #8 q = tdo;
    #(8 + stall) tck = 1'b0;
    #1;
  endtask
  task automatic pins(input logic en, input logic ev);
    logic q0;
    tap_enable_pin = en;
    probe_event_input_n = ev;
    #40;
    if (en) step(1'b0, ~tdi, q0);
  endtask
  // scans end through update, optional pause
  task automatic scan(input logic ir, input int n, input logic [31:0] v, input logic pause, output logic [31:0] q);
    logic b;
    q = '0;
    step(1'b1, ~tdi, b);
    if (ir) step(1'b1, ~tdi, b);
    step(1'b0, ~tdi, b);
    step(1'b0, ~tdi, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], b);
      q[i] = b;
    end
    if (pause) begin
      step(1'b0, ~tdi, b);
      step(1'b1, ~tdi, b);
    end
    step(1'b1, ~tdi, b);
    step(1'b0, ~tdi, b);
  endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench of the debug command port
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] DEV = 32'h0a5c_3001; // arbitrary identity value
  localparam logic [31:0] C0 = 32'h0a5c_4001; // arbitrary identity value
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] pad_in = 8'h00;
  logic [1:0][31:0] rdata = '0;
  wire tck, tms, tdi, tap_en, evt_n;
  logic tdo, tdo_oe, bdrv, own, mid;
  logic [7:0] pad_out, pv;
  logic [1:0] halt, acc, wr, go, ex;
  logic [1:0][6:0] rs;
  logic [1:0][31:0] wd;
  logic [31:0] q, v;
  logic [4:0] bcodes[3] = '{cdc_pkg::IR_SAMPLE, cdc_pkg::IR_SAMPLE_PRE, cdc_pkg::IR_EXTEST};
  logic [6:0] codes[$] = '{7'h10, 7'h12, 7'h20, 7'h23, 7'h24, 7'h25, 7'h30, 7'h31, 7'h33, 7'h70, 7'h79,
    7'h7c, 7'h7d, 7'h7e, 7'h11, 7'h7f, 7'h34, 7'h5f};
  int error_cnt = 0;
  int checks = 0;
  int got[6] = '{default: 0};
  int want[6] = '{default: 0};
  always #2 clk = ~clk;
  always @(posedge clk) for (int k = 0; k < 2; k++) begin
    got[k] += acc[k];
    got[2 + k] += go[k];
    got[4 + k] += ex[k];
  end
  cdc_debug_port #(.DEVICE_ID(DEV), .CORE0_ID(C0)) DUT (.clk(clk), .reset(reset), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .tap_enable_pin(tap_en), .probe_event_input_n(evt_n),
    .pad_in(pad_in), .pad_out(pad_out), .boundary_drive(bdrv), .core_halt_request(halt),
    .trace_owner_select(own), .master_id_select(mid), .core_access_strobe(acc), .core_access_rs(rs),
    .core_access_write(wr), .core_access_wdata(wd), .core_access_rdata(rdata), .core_go_strobe(go),
    .core_exit_strobe(ex));
  cdc_probe_model probe (.tck(tck), .tms(tms), .tdi(tdi), .tap_enable_pin(tap_en), .probe_event_input_n(evt_n),
    .tdo(tdo));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic counts;
    for (int j = 0; j < 6; j++) check(got[j], want[j]);
  endtask
  task automatic ir(input logic [4:0] c);
    probe.scan(1'b1, 5, {27'h0, c}, 1'b0, q);
    check(q, 32'(cdc_pkg::IR_CAPTURE));
  endtask
  task automatic cmd(input logic [9:0] c, input int n, input logic [31:0] d, input logic pause);
    probe.scan(1'b1, 10, {22'h0, c}, 1'b0, q);
    check(q, 32'(cdc_pkg::CMD_CAPTURE));
    probe.scan(1'b0, n, d, pause, q);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d, comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    void'($urandom(39652));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'({own, mid, halt, bdrv}), 32'h0);
    probe.pins(1'b1, 1'b1);
    probe.stall = 300;
    probe.scan(1'b0, 32, $urandom, 1'b0, q);
    probe.stall = 0;
    check(q, DEV);
    // boundary chain for each test code
    foreach (bcodes[i]) begin
      @(posedge clk) pad_in <= 8'($urandom);
      ir(bcodes[i]);
      check(32'(bdrv), 32'(bcodes[i] == cdc_pkg::IR_EXTEST));
      if (bcodes[i] == cdc_pkg::IR_EXTEST) check(32'(pad_out), 32'(pv));
      v = $urandom;
      probe.scan(1'b0, 8, v, 1'b0, q);
      check(q, 32'(pad_in));
      if (bcodes[i] == cdc_pkg::IR_SAMPLE_PRE) pv = v[7:0];
    end
    // select codes on the first core
    ir(cdc_pkg::IR_AUX_CORE0);
    foreach (codes[i]) begin
      v = $urandom;
      cmd({3'b000, codes[i]}, 32, v, 1'b0);
      if (codes[i] inside {7'h10, 7'h12, [7'h20:7'h25], [7'h30:7'h33], [7'h70:7'h79], [7'h7c:7'h7e]}) begin
        want[0]++;
        check(32'(rs[0]), 32'(codes[i]));
        check(wd[0], v);
        check(32'(wr[0]), 32'h1);
      end else check(q, {v[30:0], 1'b0});
      counts;
    end
    // read captures core data, no write
    @(posedge clk) rdata[0] <= $urandom;
    cmd(10'h230, 32, 32'h0, 1'b0);
    want[0]++;
    check(q, rdata[0]);
    check(32'(wr[0]), 32'h0);
    cmd(10'h202, 32, 32'h0, 1'b0);
    check(q, C0);
    // go and exit wait for update-DR
    probe.scan(1'b1, 10, 32'h17f, 1'b0, q);
    counts;
    probe.scan(1'b0, 1, 32'h0, 1'b0, q);
    want[2]++;
    cmd(10'h0ff, 1, 32'h0, 1'b0);
    want[4]++;
    counts;
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      v[31:30] = 2'(i + 2);
      v[27:26] = 2'(i + 2);
      v[23:22] = 2'(i + 2);
      cmd(10'h06f, 32, v, 1'b0);
      cmd(10'h26f, 32, 32'h0, 1'b0);
      check(q, v & cdc_pkg::SHARED_MASK);
      check(32'({own, mid}), 32'({v[31:30] == 2'b01, v[27:26] == 2'b01}));
      probe.pins(1'b1, 1'b0);
      check(32'(halt), 32'(v[23:22]));
      probe.pins(1'b1, 1'b1);
      check(32'(halt), 32'h0);
    end
    // pause hands the port back in bypass
    probe.scan(1'b0, 32, 32'h0, 1'b1, q);
    probe.scan(1'b0, 2, 32'h1, 1'b0, q);
    check(q, 32'h2);
    // second core sees shared code as bypass
    ir(cdc_pkg::IR_AUX_CORE1);
    cmd(10'h06f, 2, 32'h1, 1'b1);
    check(q, 32'h2);
    check(32'({own, mid}), 32'h3);
    // chained commands, second core nearest input
    ir(cdc_pkg::IR_AUX_CHAIN);
    probe.scan(1'b1, 20, {12'h0, 10'h0ff, 10'h17f}, 1'b0, q);
    check(q, {12'h0, cdc_pkg::CMD_CAPTURE, cdc_pkg::CMD_CAPTURE});
    probe.scan(1'b0, 2, 32'h0, 1'b1, q);
    want[2]++;
    want[5]++;
    counts;
    probe.pins(1'b0, 1'b1);
    check(32'({tdo_oe, bdrv}), 32'h0);
    report_and_stop;
  end
endmodule
